// ### core/ecc_pkg.sv
// Summary of operation
// R1 - four channels add a holding register
// R2 - capture empty after read or move
// R3 - holding empty only after software read
// R4 - plain capture overwrites unless no-overwrite and full
// R5 - latch on modulus zero, zero write, force
// R6 - latch mode overwrites capture and holding
// R7 - no-overwrite blocks writes into full registers
// R8 - queue capture shifts capture into holding first
// R9 - queue holding read latches and clears accumulator
// R10 - channels 0-3 have delay count filter
// R11 - accumulators count active channel edges
// R12 - saturate bit stops accumulators at 255
// R13 - accumulator pairs cascade into sixteen bits
// R14 - latch moves accumulator to holding, clears it
// R15 - modulus counter periodic base, periodic or one-shot
// R16 - channel 7 pin ownership conditions
// R17 - channels 0-6 pin ownership conditions
// R18 - masked pins driven even with timer off
// R19 - newly driven pin starts low one cycle
// R20 - active-high requests for all listed sources
// R22 - holding registers only with buffer enable
// R23 - zero modulus write holds zero, no flag
// R24 - buffered channels are channels 0 to 3
// R25 - request holds while flag and enable set
package ecc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ECC_OFS_CTRL   = 8'h00; // mode and enable bits
    localparam logic [7:0] ECC_OFS_DIR    = 8'h04; // direction [7:0], ch7 mask [15:8]
    localparam logic [7:0] ECC_OFS_NOVW   = 8'h08; // overwrite protect per channel
    localparam logic [7:0] ECC_OFS_EDGE   = 8'h0C; // two edge bits per channel
    localparam logic [7:0] ECC_OFS_FILT   = 8'h10; // filter delay count
    localparam logic [7:0] ECC_OFS_OACT   = 8'h14; // action high [7:0], low [15:8]
    localparam logic [7:0] ECC_OFS_MCNT   = 8'h18; // modulus count
    localparam logic [7:0] ECC_OFS_MCTL   = 8'h1C; // modulus control, force latch
    localparam logic [7:0] ECC_OFS_FLAGS  = 8'h20; // status flags, write one to clear
    localparam logic [7:0] ECC_OFS_IEN    = 8'h24; // request enables
    localparam logic [7:0] ECC_OFS_TCNT   = 8'h28; // main timer, read only
    localparam logic [7:0] ECC_OFS_CAP    = 8'h40; // capture 0..7, stride 4
    localparam logic [7:0] ECC_OFS_HOLD   = 8'h60; // capture holding 0..3
    localparam logic [7:0] ECC_OFS_PA     = 8'h70; // accumulators 0..3
    localparam logic [7:0] ECC_OFS_PAH    = 8'h80; // accumulator holding 0..3

    ////////////////////////////////////////////////////////////////////////////////
    // control register bit positions
    localparam int ECC_CB_TEN   = 0; // timer_enable_bit
    localparam int ECC_CB_BUFFER_ENABLE_BIT = 1; // buffer_enable_bit
    localparam int ECC_CB_LATCH_NOT_QUEUE_SELECT  = 2; // latch_not_queue_select
    localparam int ECC_CB_SAT   = 3; // accumulator_saturate_bit
    localparam int ECC_CB_PER   = 4; // modulus periodic (else one-shot)
    localparam int ECC_CB_MEN   = 5; // modulus counter enable
    localparam int ECC_CB_CASB  = 6; // cascade accumulators 1:0
    localparam int ECC_CB_CASA  = 7; // cascade accumulators 3:2
    localparam int ECC_MB_FLAT  = 0; // force_latch_bit in modulus control

    ////////////////////////////////////////////////////////////////////////////////
    // flag bit positions, channels occupy [7:0]
    localparam int ECC_FB_MZF  = 8;  // modulus_zero_flag
    localparam int ECC_FB_PBOV = 9;  // accumulator B overflow
    localparam int ECC_FB_PAIN = 10; // channel 7 input edge
    localparam int ECC_FB_PAOV = 11; // accumulator A overflow
    localparam int ECC_FB_TOF  = 12; // timer overflow
    localparam int ECC_NFLAGS  = 13;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  ECC_RST_CTRL = 8'h00;
    localparam logic [15:0] ECC_RST_MCNT = 16'hFFFF;
    localparam logic [7:0]  ECC_RST_DLY  = 8'h00;   // filter off
    localparam logic [15:0] ECC_RST_EDGE = 16'h0000; // all edges off

    // edge select encoding
    localparam logic [1:0] ECC_EDGE_RISE = 2'h1;
    localparam logic [1:0] ECC_EDGE_FALL = 2'h2;

endpackage

// ### core/ecc_filter.sv
`timescale 1ns/1ps
// input delay filter and edge detector for one channel
module ecc_filter
    import ecc_pkg::*;
#(
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // settings
    input  wire logic [DW-1:0] dly_i,
    input  wire logic [1:0]    edge_sel_i,
    // pin and event
    input  wire logic          pin_i,
    output logic               evt_o
);

    typedef struct packed {
        logic          lvl;  // accepted level
        logic [DW-1:0] cnt;  // cycles the pin has differed
        logic          evt;  // registered edge pulse
    } ecc_filt_type;

    ecc_filt_type s_q;
    ecc_filt_type s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // a new level is accepted only after dly cycles of stability; a pulse that
    // ends earlier restarts the count, so short glitches never reach the core
    always_comb begin
        s_d     = s_q;
        s_d.evt = 1'b0;
        if (pin_i == s_q.lvl) begin
            s_d.cnt = '0; // glitch ended, restart
        end else if (dly_i == '0 || s_q.cnt + 1'b1 >= dly_i) begin // R10
            s_d.lvl = pin_i;
            s_d.cnt = '0;
            s_d.evt = pin_i ? edge_sel_i[0] : edge_sel_i[1];
        end else begin
            s_d.cnt = s_q.cnt + 1'b1; // still qualifying
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evt_o = s_q.evt;

endmodule // ecc_filter

// ### core/ecc_core.sv
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
// eight channel capture timer with buffered channels and accumulators
module ecc_core
    import ecc_pkg::*;
#(
    parameter int NCH  = 8,  // channels
    parameter int NBUF = 4,  // buffered, filtered channels
    parameter int DW   = 8   // filter count width
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic [7:0]       adr_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    output logic                  ack_o,
    // channel pins
    input  wire logic [NCH-1:0]   cap_pin_i,
    input  wire logic [NCH-1:0]   oc_level_i,
    output logic [NCH-1:0]        oc_pin_o,
    output logic [NCH-1:0]        oc_oe_o,
    // interrupt requests
    output logic [NCH-1:0]        irq_chan_o,
    output logic                  irq_mod_o,
    output logic                  irq_pbov_o,
    output logic                  irq_pain_o,
    output logic                  irq_paov_o,
    output logic                  irq_tof_o
);

    typedef struct packed {
        logic                        ack;       // bus answer
        logic [31:0]                 rdat;      // registered read data
        logic [7:0]                  ctrl;      // mode bits
        logic [NCH-1:0]              dir;       // channel_direction_reg
        logic [NCH-1:0]              mask7;     // channel7_mask_bit per channel
        logic [NCH-1:0]              novw;      // overwrite_protect_reg
        logic [2*NCH-1:0]            edge_sel;  // active edge selection
        logic [DW-1:0]               dly;       // filter_delay_count
        logic [NCH-1:0]              om;        // output_action_high_bit
        logic [NCH-1:0]              ol;        // output_action_low_bit
        logic [15:0]                 tcnt;      // main timer
        logic [15:0]                 mload;     // modulus reload
        logic [15:0]                 mcnt;      // modulus count
        logic                        mshot;     // one-shot latch spent
        logic [ECC_NFLAGS-1:0]       flags;     // sticky events
        logic [ECC_NFLAGS-1:0]       ien;       // request enables
        logic [NCH-1:0][15:0]        cap;       // capture registers
        logic [NCH-1:0]              cap_full;  // capture not yet empty
        logic [NBUF-1:0][15:0]       hold;      // capture holding R1
        logic [NBUF-1:0]             hold_full; // holding not yet read
        logic [NBUF-1:0][7:0]        pa;        // pulse accumulators
        logic [NBUF-1:0][7:0]        pah;       // accumulator holding
        logic [NCH-1:0]              oe;        // pin owned by compare
        logic [NCH-1:0]              pin;       // pin level
    } ecc_state_type;

    ecc_state_type  s_q;
    ecc_state_type  s_d;
    logic [NCH-1:0] evt;  // filtered channel edges

    ////////////////////////////////////////////////////////////////////////////////
    // byte lane merge for register writes
    function automatic logic [31:0] ecc_lane(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // input filters; only the buffered channels get a delay count
    for (genvar g = 0; g < NCH; g++) begin : g_filt
        ecc_filter #(.DW(DW)) u_filt (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .dly_i      ((g < NBUF) ? s_q.dly : {DW{1'b0}}), // R10
            .edge_sel_i (s_q.edge_sel[2*g +: 2]),
            .pin_i      (cap_pin_i[g]),
            .evt_o      (evt[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state: bus effects first, then hardware events so that sets win
    always_comb begin
        logic        req;      // new bus cycle
        logic        wr;       // write strobe
        logic        rd;       // read strobe
        logic        zw;       // zero written to modulus
        logic        flat;     // force latch written
        logic        mzero;    // modulus reached zero
        logic        lat;      // latch event for holding registers
        logic        buffer_enable_bit;    // holding registers active
        logic        latch_not_queue_select;     // latch mode when set, queue when clear
        logic        sat;      // accumulators saturate
        logic [31:0] wv;       // merged write value
        logic [NBUF-1:0] qrd;  // queue mode holding reads
        logic [ECC_NFLAGS-1:0] fset; // flag sets
        logic [16:0] sum;      // cascaded accumulator sum
        logic [8:0]  inc;      // single accumulator sum
        req   = cyc_i & stb_i & ~s_q.ack;
        wr    = req & we_i;
        rd    = req & ~we_i;
        zw    = 1'b0;
        flat  = 1'b0;
        mzero = 1'b0;
        lat   = 1'b0;
        qrd   = '0;
        fset  = '0;
        sum   = '0;
        inc   = '0;
        wv    = 32'h0000_0000;
        buffer_enable_bit = s_q.ctrl[ECC_CB_BUFFER_ENABLE_BIT];
        latch_not_queue_select  = s_q.ctrl[ECC_CB_LATCH_NOT_QUEUE_SELECT];
        sat   = s_q.ctrl[ECC_CB_SAT];
        s_d      = s_q;
        s_d.ack  = req;
        s_d.rdat = 32'h0000_0000;

        // register writes
        if (wr) begin
            case (adr_i)
                ECC_OFS_CTRL: begin
                    wv         = ecc_lane({24'h0, s_q.ctrl}, dat_i, sel_i);
                    s_d.ctrl   = wv[7:0];
                end
                ECC_OFS_DIR: begin
                    wv         = ecc_lane({16'h0, s_q.mask7, s_q.dir}, dat_i, sel_i);
                    s_d.dir    = wv[7:0];
                    s_d.mask7  = wv[15:8];
                end
                ECC_OFS_NOVW: begin
                    wv         = ecc_lane({24'h0, s_q.novw}, dat_i, sel_i);
                    s_d.novw   = wv[7:0];
                end
                ECC_OFS_EDGE: begin
                    wv           = ecc_lane({16'h0, s_q.edge_sel}, dat_i, sel_i);
                    s_d.edge_sel = wv[15:0];
                end
                ECC_OFS_FILT: begin
                    wv         = ecc_lane({24'h0, s_q.dly}, dat_i, sel_i);
                    s_d.dly    = wv[7:0];
                end
                ECC_OFS_OACT: begin
                    wv         = ecc_lane({16'h0, s_q.ol, s_q.om}, dat_i, sel_i);
                    s_d.om     = wv[7:0];
                    s_d.ol     = wv[15:8];
                end
                ECC_OFS_MCNT: begin
                    // a full word is expected; lanes still merge
                    wv        = ecc_lane({16'h0, s_q.mload}, dat_i, sel_i);
                    s_d.mload = wv[15:0];
                    s_d.mcnt  = wv[15:0];
                    s_d.mshot = 1'b0;
                    zw        = (wv[15:0] == 16'h0000); // R23
                end
                ECC_OFS_MCTL: begin
                    flat = sel_i[0] & dat_i[ECC_MB_FLAT]; // R5
                end
                ECC_OFS_FLAGS: begin
                    wv        = ecc_lane(32'h0, dat_i, sel_i);
                    s_d.flags = s_q.flags & ~wv[ECC_NFLAGS-1:0]; // R25
                end
                ECC_OFS_IEN: begin
                    wv      = ecc_lane({19'h0, s_q.ien}, dat_i, sel_i);
                    s_d.ien = wv[ECC_NFLAGS-1:0];
                end
                default: begin
                    // unmapped or read-only: acknowledged, no effect
                end
            endcase
        end

        // register reads, with their emptying side effects
        if (rd) begin
            case (adr_i)
                ECC_OFS_CTRL:  s_d.rdat = {24'h0, s_q.ctrl};
                ECC_OFS_DIR:   s_d.rdat = {16'h0, s_q.mask7, s_q.dir};
                ECC_OFS_NOVW:  s_d.rdat = {24'h0, s_q.novw};
                ECC_OFS_EDGE:  s_d.rdat = {16'h0, s_q.edge_sel};
                ECC_OFS_FILT:  s_d.rdat = {24'h0, s_q.dly};
                ECC_OFS_OACT:  s_d.rdat = {16'h0, s_q.ol, s_q.om};
                ECC_OFS_MCNT:  s_d.rdat = {16'h0, s_q.mcnt};
                ECC_OFS_FLAGS: s_d.rdat = {19'h0, s_q.flags};
                ECC_OFS_IEN:   s_d.rdat = {19'h0, s_q.ien};
                ECC_OFS_TCNT:  s_d.rdat = {16'h0, s_q.tcnt};
                default: begin
                    for (int n = 0; n < NCH; n++) begin
                        if (adr_i == ECC_OFS_CAP + 8'(4 * n)) begin
                            s_d.rdat        = {16'h0, s_q.cap[n]};
                            s_d.cap_full[n] = 1'b0; // R2
                        end
                    end
                    for (int n = 0; n < NBUF; n++) begin
                        if (adr_i == ECC_OFS_HOLD + 8'(4 * n)) begin
                            s_d.rdat         = {16'h0, s_q.hold[n]};
                            s_d.hold_full[n] = 1'b0; // R3
                            qrd[n]           = buffer_enable_bit & ~latch_not_queue_select; // R9
                        end
                        if (adr_i == ECC_OFS_PA + 8'(4 * n)) begin
                            s_d.rdat = {24'h0, s_q.pa[n]};
                        end
                        if (adr_i == ECC_OFS_PAH + 8'(4 * n)) begin
                            s_d.rdat = {24'h0, s_q.pah[n]};
                        end
                    end
                end
            endcase
        end

        // main timer; its prescaler lives outside this block
        if (s_q.ctrl[ECC_CB_TEN]) begin
            s_d.tcnt = s_q.tcnt + 16'h0001;
            fset[ECC_FB_TOF] = (s_q.tcnt == 16'hFFFF);
        end

        // modulus down-counter; a counter parked at zero stays there
        if (s_q.ctrl[ECC_CB_MEN] && !wr_mcnt(wr, adr_i) && s_q.mcnt != 16'h0000) begin // R23
            if (s_q.mcnt == 16'h0001) begin
                mzero    = 1'b1;
                fset[ECC_FB_MZF] = 1'b1; // R15
                s_d.mcnt = s_q.ctrl[ECC_CB_PER] ? s_q.mload : 16'h0000; // R15
            end else begin
                s_d.mcnt = s_q.mcnt - 16'h0001;
            end
        end

        // latch event: one-shot mode latches only on the first zero
        lat = buffer_enable_bit & latch_not_queue_select & ((mzero & (s_q.ctrl[ECC_CB_PER] | ~s_q.mshot))
                              | zw | flat); // R5 R22
        if (mzero && latch_not_queue_select && buffer_enable_bit) begin
            s_d.mshot = 1'b1; // R15
        end

        // capture channels
        for (int n = 0; n < NCH; n++) begin
            if (n < NBUF && buffer_enable_bit && lat) begin
                // latch copies capture into holding
                if (!s_q.novw[n] || !s_d.hold_full[n]) begin // R6 R7
                    s_d.hold[n]      = s_d.cap[n];
                    s_d.hold_full[n] = 1'b1;
                    s_d.cap_full[n]  = 1'b0; // R2
                end
            end
            if (evt[n] && !s_q.dir[n]) begin
                if (n < NBUF && buffer_enable_bit && !latch_not_queue_select) begin // R24
                    // queue: shift capture into holding, then store
                    if (!s_q.novw[n]) begin // R8
                        s_d.hold[n]      = s_d.cap[n];
                        s_d.hold_full[n] = s_d.cap_full[n] | s_d.hold_full[n];
                        s_d.cap[n]       = s_q.tcnt;
                        s_d.cap_full[n]  = 1'b1;
                        fset[n]          = 1'b1;
                    end else if (!s_d.cap_full[n]) begin // R7
                        s_d.cap[n]       = s_q.tcnt;
                        s_d.cap_full[n]  = 1'b1;
                        fset[n]          = 1'b1;
                    end else if (!s_d.hold_full[n]) begin // R7
                        s_d.hold[n]      = s_d.cap[n];
                        s_d.hold_full[n] = 1'b1;
                        s_d.cap[n]       = s_q.tcnt;
                        fset[n]          = 1'b1;
                    end
                end else if (!s_q.novw[n] || !s_d.cap_full[n]) begin // R4 R7
                    // plain or latch-mode capture
                    s_d.cap[n]      = s_q.tcnt;
                    s_d.cap_full[n] = 1'b1;
                    fset[n]         = 1'b1;
                end
            end
        end

        // accumulator holding transfers clear the accumulator
        for (int n = 0; n < NBUF; n++) begin
            if ((lat || qrd[n]) && buffer_enable_bit) begin // R14 R9 R22
                s_d.pah[n] = s_q.pa[n];
                s_d.pa[n]  = 8'h00;
            end
        end

        // accumulator counting, pairs may cascade into sixteen bits
        for (int p = 0; p < NBUF / 2; p++) begin
            if (s_q.ctrl[ECC_CB_CASB + p]) begin
                if (evt[2*p]) begin // R13
                    sum = {1'b0, s_d.pa[2*p+1], s_d.pa[2*p]} + 17'h00001;
                    {s_d.pa[2*p+1], s_d.pa[2*p]} = sum[15:0];
                    fset[p == 0 ? ECC_FB_PBOV : ECC_FB_PAOV] = sum[16];
                end
            end else begin
                for (int k = 2 * p; k < 2 * p + 2; k++) begin
                    if (evt[k]) begin // R11
                        inc = {1'b0, s_d.pa[k]} + 9'h001;
                        if (!(sat && s_d.pa[k] == 8'hFF)) begin // R12
                            s_d.pa[k] = inc[7:0];
                        end
                        if (k == 2 * p + 1 && inc[8]) begin
                            // upper byte wrap or saturated extra edge
                            fset[p == 0 ? ECC_FB_PBOV : ECC_FB_PAOV] = 1'b1;
                        end
                    end
                end
            end
        end
        fset[ECC_FB_PAIN] = evt[NCH-1];

        // flags: a set in the same cycle as a clear wins
        s_d.flags = s_d.flags | fset; // R20

        // pin ownership and initial low level
        for (int n = 0; n < NCH; n++) begin
            s_d.oe[n] = (s_q.ctrl[ECC_CB_TEN] & s_q.dir[n] & (s_q.om[n] | s_q.ol[n]))
                      | (s_q.mask7[n] & s_q.dir[NCH-1] & s_q.dir[n]); // R16 R17 R18
            s_d.pin[n] = (s_q.oe[n] & s_d.oe[n]) ? oc_level_i[n] : 1'b0; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // true for a write to the modulus count, which overrides counting
    function automatic logic wr_mcnt(input logic w, input logic [7:0] a);
        return w && (a == ECC_OFS_MCNT);
    endfunction

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.ctrl     <= ECC_RST_CTRL;
            s_q.mload    <= ECC_RST_MCNT;
            s_q.mcnt     <= ECC_RST_MCNT;
            s_q.dly      <= ECC_RST_DLY;
            s_q.edge_sel <= ECC_RST_EDGE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; requests are level, held while flag and enable are set
    assign dat_o      = s_q.rdat;
    assign ack_o      = s_q.ack;
    assign oc_oe_o    = s_q.oe;
    assign oc_pin_o   = s_q.pin;
    assign irq_chan_o = s_q.flags[NCH-1:0] & s_q.ien[NCH-1:0]; // R20 R25
    assign irq_mod_o  = s_q.flags[ECC_FB_MZF] & s_q.ien[ECC_FB_MZF];
    assign irq_pbov_o = s_q.flags[ECC_FB_PBOV] & s_q.ien[ECC_FB_PBOV];
    assign irq_pain_o = s_q.flags[ECC_FB_PAIN] & s_q.ien[ECC_FB_PAIN];
    assign irq_paov_o = s_q.flags[ECC_FB_PAOV] & s_q.ien[ECC_FB_PAOV];
    assign irq_tof_o  = s_q.flags[ECC_FB_TOF] & s_q.ien[ECC_FB_TOF];

endmodule // ecc_core

// ### tb/ecc_pins_model.sv
`timescale 1ns/1ps
// far side: capture pulses on demand, compare level flips every cycle
module ecc_pins_model (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] go_i,  // channels to pulse
    input wire logic [3:0] wid_i, // extra high cycles
    output logic     [7:0] pin_o,
    output logic     [7:0] lvl_o
);
    logic [3:0] cnt_q; // cycles left in pulse
    // a changing level so a stale pin value cannot pass by luck
    always @(posedge clk_i) begin
        lvl_o <= rst_i ? 8'h00 : ~lvl_o;
        cnt_q <= rst_i ? 4'h0 : (go_i != 0 ? wid_i : (cnt_q != 0 ? cnt_q - 4'h1 : 4'h0));
        pin_o <= rst_i ? 8'h00 : (go_i != 0 ? go_i : (cnt_q != 0 ? pin_o : 8'h00));
    end
endmodule // ecc_pins_model

// ### tb/ecc_core_chk.sv
`timescale 1ns/1ps
// port watcher: bus handshake, compare pin ownership, requests
module ecc_core_chk #(parameter int NCH = 8) (
    input wire logic           clk_i, rst_i, cyc_i, stb_i, ack_o, irq_mod_o,
    input wire logic [31:0]    dat_o,
    input wire logic [NCH-1:0] oc_level_i, oc_pin_o, oc_oe_o, irq_chan_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_dat_idle; !ack_o |-> dat_o == 0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    property p_pin_free; (oc_pin_o & ~oc_oe_o) == 0; endproperty
    a_pin_free: assert property (p_pin_free) else $error("pin high unowned");
    property p_pin_start; (oc_oe_o & ~$past(oc_oe_o) & oc_pin_o) == 0; endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin not low first");
    // owned pin copies the compare level one cycle late
    property p_pin_follow;
        (oc_oe_o & $past(oc_oe_o) & (oc_pin_o ^ $past(oc_level_i))) == 0;
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin level");
    property p_rst_quiet; $fell(rst_i) |-> !irq_mod_o && irq_chan_o == 0 && oc_oe_o == 0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
    c_ack: cover property (ack_o);
    c_own: cover property ($rose(|oc_oe_o));
    c_mod: cover property ($rose(irq_mod_o));
endmodule // ecc_core_chk
bind ecc_core ecc_core_chk #(.NCH(NCH)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
    .irq_mod_o, .dat_o, .oc_level_i, .oc_pin_o, .oc_oe_o, .irq_chan_o);

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ecc_pkg::*;
    logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o, irq_mod_o;
    logic [7:0]  adr_i = 0, cap_pin_i, oc_level_i, oc_pin_o, oc_oe_o, irq_chan_o, go = 0;
    logic [31:0] dat_i = 0, dat_o, q, c4;
    logic [3:0]  sel_i = 4'hF, wid = 4'h8;
    int          num_errors = 0, cmp_count = 0;
    // rows: address, write byte, expected read back
    logic [23:0] rows [4] = '{24'h10_05_05, 24'h08_F0_F0, 24'h3C_AA_00, 24'h1C_01_00};
    initial forever #12.5 clk_i = ~clk_i;
    ecc_core DUT (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i,
        .ack_o, .cap_pin_i, .oc_level_i, .oc_pin_o, .oc_oe_o, .irq_chan_o, .irq_mod_o,
        .irq_pbov_o(), .irq_pain_o(), .irq_paov_o(), .irq_tof_o());
    ecc_pins_model pins (.clk_i, .rst_i, .go_i(go), .wid_i(wid), .pin_o(cap_pin_i),
        .lvl_o(oc_level_i));
    task give_verdict;
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, e, s);
        end
    endtask
    // one classic cycle; ack and data taken at the edge, then one idle cycle
    task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        {adr_i, dat_i, we_i, cyc_i, stb_i} <= {a, d, w, 2'b11};
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (n >= 50) begin num_errors++; give_verdict; end
        @(posedge clk_i);
    endtask
    task pulse(input logic [7:0] c);
        go <= c;
        @(posedge clk_i);
        go <= 8'h00;
        repeat (20) @(posedge clk_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        bus(ECC_OFS_MCNT, 32'h0, 0); chk("mcnt reset", q, 32'hFFFF);
        foreach (rows[i]) begin
            bus(rows[i][23:16], {24'h0, rows[i][15:8]}, 1);
            bus(rows[i][23:16], 32'h0, 0); chk("reg", q, {24'h0, rows[i][7:0]});
        end
        // ch4 protected, ch5 free, ch6 one edge only
        bus(ECC_OFS_CTRL, 32'h1, 1); bus(ECC_OFS_EDGE, 32'h1501, 1); bus(ECC_OFS_NOVW, 32'h10, 1);
        pulse(8'h70); pulse(8'h30);
        bus(8'h50, 32'h0, 0); c4 = q;
        bus(8'h58, 32'h0, 0); chk("cap4 kept", c4, q);
        bus(8'h54, 32'h0, 0); chk("cap5 new", c4 == q, 32'h0);
        // latch mode on a filtered buffered channel
        bus(ECC_OFS_CTRL, 32'h7, 1); repeat (3) pulse(8'h01);
        bus(ECC_OFS_PA, 32'h0, 0); chk("pa0", q, 32'h3);
        bus(ECC_OFS_MCTL, 32'h1, 1); bus(ECC_OFS_PAH, 32'h0, 0); chk("pah0", q, 32'h3);
        wid <= 4'h2; pulse(8'h01); // too short for the filter
        bus(ECC_OFS_PA, 32'h0, 0); chk("pa0 clear", q, 32'h0);
        // pin ownership: mask without timer, then action with timer
        bus(ECC_OFS_CTRL, 32'h0, 1); bus(ECC_OFS_DIR, 32'h8486, 1);
        chk("oe masked", oc_oe_o, 32'h84);
        bus(ECC_OFS_OACT, 32'h2, 1); bus(ECC_OFS_CTRL, 32'h1, 1);
        chk("oe action", oc_oe_o, 32'h86);
        // modulus: zero write parks silently, one-shot sets flag once
        bus(ECC_OFS_IEN, 32'h170, 1); bus(ECC_OFS_CTRL, 32'h21, 1); bus(ECC_OFS_MCNT, 32'h0, 1);
        chk("chan irq", irq_chan_o, 32'h70);
        repeat (10) @(posedge clk_i);
        chk("mod zero write", irq_mod_o, 32'h0);
        bus(ECC_OFS_MCNT, 32'h0, 0); chk("mcnt parked", q, 32'h0);
        bus(ECC_OFS_MCNT, 32'h4, 1); repeat (10) @(posedge clk_i);
        chk("mod irq", irq_mod_o, 32'h1);
        bus(ECC_OFS_FLAGS, 32'h100, 1); repeat (10) @(posedge clk_i);
        chk("mod irq clear", irq_mod_o, 32'h0);
        give_verdict;
    end
endmodule // testbench
